// file: rtl/status_error_remote_cmds.sv
// Status nodes, error queue and serial remote-session control
// Summary of operation
// R1: Condition queries on operation or questionable node always answer zero.
// R2: Event queries on operation or questionable node always answer zero.
// R3: Enable-set stores a value 0 to 32767 into the chosen node.
// R4: Enable query returns the stored value and changes nothing.
// R5: Status preset loads zero into both enable registers.
// R6: Pending errors sit in a 100-entry first-in first-out queue.
// R7: Each error query pops the oldest entry, returning code and text.
// R8: Repeated error queries give errors in order of occurrence.
// R9: Empty queue answers code zero with the no-errors message.
// R10: Error query accepted on both ports; status commands on GPIB only.
// R11: Serial open command grants serial remote and locks the keyboard.
// R12: Controller sends serial open before any other serial command.
// R13: Local key returns to local and stops serial command acceptance.
// R14: Serial close acts exactly like the local key.
// R15: A full queue drops new errors instead of overwriting unread ones.
`timescale 1ns/1ps
`default_nettype none
module status_error_remote_cmds
  import status_cmd_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CMD_VALID_IN,
  input wire cmd_t CMD_CODE_IN,
  input wire port_t CMD_PORT_IN,
  input wire logic [VAL_W-1:0] CMD_VALUE_IN,
  input wire logic LOCAL_KEY_IN,
  input wire logic ERR_PUSH_IN,
  input wire logic [CODE_W-1:0] ERR_CODE_IN,
  input wire logic [TEXT_W-1:0] ERR_TEXT_IN,
  output logic RESP_VALID_OUT,
  output logic [VAL_W-1:0] RESP_VALUE_OUT,
  output logic [TEXT_W-1:0] RESP_TEXT_OUT,
  output logic CMD_REJECT_OUT,
  output logic SERIAL_REMOTE_OUT,
  output logic KEYBOARD_LOCK_OUT,
  output logic ERR_DROP_OUT,
  output logic [VAL_W-1:0] OPER_ENABLE_OUT,
  output logic [VAL_W-1:0] QUES_ENABLE_OUT
);
  logic [VAL_W-1:0] operation_event_enable_reg;
  logic [VAL_W-1:0] questionable_event_enable_reg;
  logic [CODE_W-1:0] code_mem [QDEPTH];
  logic [TEXT_W-1:0] text_mem [QDEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic serial_remote_reg;
  logic accepted;
  logic is_status_cmd;
  logic is_serial_ctl;
  logic pop;
  logic push;
  logic q_empty;
  logic q_full;

  // Status commands need GPIB; session commands need serial; error query either port
  assign is_status_cmd = (CMD_CODE_IN != CMD_ERROR_Q) && (CMD_CODE_IN != CMD_SERIAL_OPEN)
                      && (CMD_CODE_IN != CMD_SERIAL_CLOSE) && (CMD_CODE_IN != CMD_NONE);
  assign is_serial_ctl = (CMD_CODE_IN == CMD_SERIAL_OPEN) || (CMD_CODE_IN == CMD_SERIAL_CLOSE);
  always_comb begin
    accepted = 1'b0;
    if (CMD_VALID_IN) begin
      if (CMD_PORT_IN == PORT_GPIB) begin
        accepted = is_status_cmd || (CMD_CODE_IN == CMD_ERROR_Q); // R10
      end else if (CMD_CODE_IN == CMD_SERIAL_OPEN) begin
        accepted = 1'b1; // R11
      end else begin
        // Serial traffic other than open is ignored until a session is open
        accepted = serial_remote_reg && ((CMD_CODE_IN == CMD_ERROR_Q) || is_serial_ctl); // R12
      end
    end
  end

  assign q_empty = (count_reg == CNT_ZERO);
  assign q_full = (count_reg == CNT_FULL);
  assign pop = accepted && (CMD_CODE_IN == CMD_ERROR_Q) && !q_empty; // R7
  // A pop frees a slot in the same cycle, so a push into a full queue then fits
  assign push = ERR_PUSH_IN && (!q_full || pop); // R15

  // Enable registers, visible on their own outputs
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      operation_event_enable_reg <= ENABLE_RESET;
      questionable_event_enable_reg <= ENABLE_RESET;
    end else if (accepted) begin
      unique case (CMD_CODE_IN)
        CMD_OPER_ENABLE_SET: operation_event_enable_reg <= CMD_VALUE_IN & ENABLE_MAX; // R3
        CMD_QUES_ENABLE_SET: questionable_event_enable_reg <= CMD_VALUE_IN & ENABLE_MAX; // R3
        CMD_STATUS_PRESET: begin
          operation_event_enable_reg <= ENABLE_RESET; // R5
          questionable_event_enable_reg <= ENABLE_RESET; // R5
        end
        default: begin
        end
      endcase
    end
  end
  assign OPER_ENABLE_OUT = operation_event_enable_reg;
  assign QUES_ENABLE_OUT = questionable_event_enable_reg;

  // Queue storage; no reset needed as entries are read only when counted
  always_ff @(posedge CLK_SYS_IN) begin
    if (push) begin
      code_mem[wr_ptr_reg] <= ERR_CODE_IN; // R6
      text_mem[wr_ptr_reg] <= ERR_TEXT_IN;
    end
  end

  // Pointers wrap at the hundredth slot
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wr_ptr_reg <= PTR_ZERO;
      rd_ptr_reg <= PTR_ZERO;
      count_reg <= CNT_ZERO;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? PTR_ZERO : wr_ptr_reg + 7'h01; // R6
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? PTR_ZERO : rd_ptr_reg + 7'h01; // R8
      end
      if (push && !pop) begin
        count_reg <= count_reg + 7'h01;
      end else if (pop && !push) begin
        count_reg <= count_reg - 7'h01;
      end
    end
  end

  // Dropped-error pulse for diagnostics
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ERR_DROP_OUT <= 1'b0;
    end else begin
      ERR_DROP_OUT <= ERR_PUSH_IN && !push; // R15
    end
  end

  // Serial session; local key wins over a simultaneous open
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      serial_remote_reg <= 1'b0;
    end else if (LOCAL_KEY_IN) begin
      serial_remote_reg <= 1'b0; // R13
    end else if (accepted && CMD_CODE_IN == CMD_SERIAL_CLOSE) begin
      serial_remote_reg <= 1'b0; // R14
    end else if (accepted && CMD_CODE_IN == CMD_SERIAL_OPEN) begin
      serial_remote_reg <= 1'b1; // R11
    end
  end
  assign SERIAL_REMOTE_OUT = serial_remote_reg;
  assign KEYBOARD_LOCK_OUT = serial_remote_reg; // R11

  // Answers, one cycle after the command
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RESP_VALID_OUT <= 1'b0;
      RESP_VALUE_OUT <= ZERO_VALUE;
      RESP_TEXT_OUT <= NO_ERROR_TEXT;
      CMD_REJECT_OUT <= 1'b0;
    end else begin
      RESP_VALID_OUT <= 1'b0;
      RESP_VALUE_OUT <= ZERO_VALUE;
      RESP_TEXT_OUT <= NO_ERROR_TEXT;
      CMD_REJECT_OUT <= CMD_VALID_IN && !accepted && (CMD_CODE_IN != CMD_NONE);
      if (accepted) begin
        unique case (CMD_CODE_IN)
          CMD_OPER_COND_Q, CMD_QUES_COND_Q: RESP_VALID_OUT <= 1'b1; // R1
          CMD_OPER_EVENT_Q, CMD_QUES_EVENT_Q: RESP_VALID_OUT <= 1'b1; // R2
          CMD_OPER_ENABLE_Q: begin
            RESP_VALID_OUT <= 1'b1;
            RESP_VALUE_OUT <= operation_event_enable_reg; // R4
          end
          CMD_QUES_ENABLE_Q: begin
            RESP_VALID_OUT <= 1'b1;
            RESP_VALUE_OUT <= questionable_event_enable_reg; // R4
          end
          CMD_ERROR_Q: begin
            RESP_VALID_OUT <= 1'b1;
            if (q_empty) begin
              RESP_VALUE_OUT <= NO_ERROR_CODE; // R9
              RESP_TEXT_OUT <= NO_ERROR_TEXT;
            end else begin
              RESP_VALUE_OUT <= code_mem[rd_ptr_reg]; // R7
              RESP_TEXT_OUT <= text_mem[rd_ptr_reg];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Checks
  a_count_bound: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    count_reg <= CNT_FULL) else $error("queue count above depth"); // R6
  a_cond_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && (CMD_CODE_IN == CMD_OPER_COND_Q || CMD_CODE_IN == CMD_QUES_COND_Q)
    |=> RESP_VALID_OUT && RESP_VALUE_OUT == ZERO_VALUE) else $error("condition not zero"); // R1
  a_event_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && (CMD_CODE_IN == CMD_OPER_EVENT_Q || CMD_CODE_IN == CMD_QUES_EVENT_Q)
    |=> RESP_VALID_OUT && RESP_VALUE_OUT == ZERO_VALUE) else $error("event not zero"); // R2
  a_enable_store: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && CMD_CODE_IN == CMD_OPER_ENABLE_SET
    |=> operation_event_enable_reg == ($past(CMD_VALUE_IN) & ENABLE_MAX))
    else $error("operation enable not stored"); // R3
  a_enable_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && CMD_CODE_IN == CMD_QUES_ENABLE_Q
    |=> RESP_VALUE_OUT == $past(questionable_event_enable_reg)
    && $stable(questionable_event_enable_reg) && $stable(operation_event_enable_reg))
    else $error("enable query wrong"); // R4
  a_preset_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && CMD_CODE_IN == CMD_STATUS_PRESET
    |=> operation_event_enable_reg == ENABLE_RESET
    && questionable_event_enable_reg == ENABLE_RESET) else $error("preset failed"); // R5
  a_empty_answer: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && CMD_CODE_IN == CMD_ERROR_Q && q_empty
    |=> RESP_VALUE_OUT == NO_ERROR_CODE && RESP_VALID_OUT) else $error("empty answer"); // R9
  a_pop_count: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    pop && !push |=> count_reg == $past(count_reg) - 7'h01) else $error("pop lost"); // R8
  a_full_drop: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    ERR_PUSH_IN && q_full && !pop |=> ERR_DROP_OUT && count_reg == CNT_FULL)
    else $error("full queue not dropping"); // R15
  a_gpib_only: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    CMD_VALID_IN && CMD_PORT_IN == PORT_SERIAL && is_status_cmd |=> CMD_REJECT_OUT)
    else $error("status cmd on serial taken"); // R10
  a_local_key: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    LOCAL_KEY_IN |=> !serial_remote_reg ##1 1'b1) else $error("local key ignored"); // R13
  a_close_local: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && CMD_CODE_IN == CMD_SERIAL_CLOSE |=> !KEYBOARD_LOCK_OUT)
    else $error("close kept lock"); // R14
  a_open_lock: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    CMD_VALID_IN && CMD_PORT_IN == PORT_SERIAL && CMD_CODE_IN == CMD_SERIAL_OPEN
    && !LOCAL_KEY_IN |=> KEYBOARD_LOCK_OUT) else $error("open not locking"); // R11
  c_queue_full: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) q_full);
  c_error_pop: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) pop ##1 pop);
  c_session: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    serial_remote_reg ##[1:20] !serial_remote_reg);
  c_preset: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accepted && CMD_CODE_IN == CMD_STATUS_PRESET);
endmodule
`default_nettype wire

// file: rtl/status_cmd_pkg.sv
// Package: command codes, field widths and constants of the status command block
package status_cmd_pkg;
  localparam int VAL_W = 16;
  localparam int CODE_W = 16;
  localparam int TEXT_W = 8;
  localparam int QDEPTH = 100;
  localparam int PTR_W = 7;
  localparam int CNT_W = 7;
  localparam logic [VAL_W-1:0] ENABLE_MAX = 16'h7FFF;
  localparam logic [VAL_W-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [VAL_W-1:0] ZERO_VALUE = 16'h0000;
  localparam logic [CODE_W-1:0] NO_ERROR_CODE = 16'h0000;
  localparam logic [TEXT_W-1:0] NO_ERROR_TEXT = 8'h00;
  localparam logic [PTR_W-1:0] PTR_LAST = 7'h63;
  localparam logic [PTR_W-1:0] PTR_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 7'h64;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_OPER_COND_Q,
    CMD_QUES_COND_Q,
    CMD_OPER_EVENT_Q,
    CMD_QUES_EVENT_Q,
    CMD_OPER_ENABLE_SET,
    CMD_QUES_ENABLE_SET,
    CMD_OPER_ENABLE_Q,
    CMD_QUES_ENABLE_Q,
    CMD_STATUS_PRESET,
    CMD_ERROR_Q,
    CMD_SERIAL_OPEN,
    CMD_SERIAL_CLOSE
  } cmd_t;
  typedef enum logic {
    PORT_GPIB,
    PORT_SERIAL
  } port_t;
endpackage

// file: tb/remote_ctrl_model.sv
// Remote controller model that presents decoded commands to the block
`timescale 1ns/1ps
`default_nettype none
module remote_ctrl_model
  import status_cmd_pkg::*;
(
  input wire logic clk_in,
  input wire logic go_in,
  input wire cmd_t code_in,
  input wire port_t port_in,
  input wire logic [VAL_W-1:0] value_in,
  output logic valid_out,
  output cmd_t code_out,
  output port_t port_out,
  output logic [VAL_W-1:0] value_out
);
  logic [VAL_W-1:0] last_reg = 16'h0000;
  // Idle value bus shows the inverse of the last value so stale data never looks valid
  assign valid_out = go_in;
  assign code_out = go_in ? code_in : CMD_NONE;
  assign port_out = port_in;
  assign value_out = go_in ? (value_in & ENABLE_MAX) : ~last_reg;
  // Remember the last value sent
  always @(posedge clk_in) begin
    if (go_in) begin
      last_reg <= value_in & ENABLE_MAX;
    end
  end
endmodule
`default_nettype wire

// file: tb/status_error_remote_cmds_tb.sv
// Self-checking testbench of the status, error queue and serial session block
`timescale 1ns/1ps
`default_nettype none
module status_error_remote_cmds_tb;
  import status_cmd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, go, local_key, err_push, cv, rv, rej, remote, lock, drop;
  cmd_t code, cc;
  port_t port, cp;
  logic [VAL_W-1:0] val, cval, rval, oper_en, ques_en, v;
  logic [CODE_W-1:0] err_code;
  logic [TEXT_W-1:0] err_text, rtext;
  logic [23:0] q[$];
  logic [23:0] e;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 32'h0f83;

  always #25 clk_sys = ~clk_sys;

  remote_ctrl_model remote_ctrl_model_i (.clk_in(clk_sys), .go_in(go), .code_in(code),
    .port_in(port), .value_in(val), .valid_out(cv), .code_out(cc), .port_out(cp),
    .value_out(cval));
  status_error_remote_cmds status_error_remote_cmds_i (.CLK_SYS_IN(clk_sys),
    .RST_N_IN(rst_n), .CMD_VALID_IN(cv), .CMD_CODE_IN(cc), .CMD_PORT_IN(cp),
    .CMD_VALUE_IN(cval), .LOCAL_KEY_IN(local_key), .ERR_PUSH_IN(err_push),
    .ERR_CODE_IN(err_code), .ERR_TEXT_IN(err_text), .RESP_VALID_OUT(rv),
    .RESP_VALUE_OUT(rval), .RESP_TEXT_OUT(rtext), .CMD_REJECT_OUT(rej),
    .SERIAL_REMOTE_OUT(remote), .KEYBOARD_LOCK_OUT(lock), .ERR_DROP_OUT(drop),
    .OPER_ENABLE_OUT(oper_en), .QUES_ENABLE_OUT(ques_en));

  function automatic logic [VAL_W-1:0] exp_enable(input logic [VAL_W-1:0] x);
    return x & ENABLE_MAX;
  endfunction

  task chk(input logic [VAL_W-1:0] got, input logic [VAL_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task chk_text(input logic [TEXT_W-1:0] got, input logic [TEXT_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t text got %h expected %h", $time, got, exp);
    end
  endtask

  // One command: held for exactly one rising edge, answer sampled at the next falling edge
  task cmd(input cmd_t c, input port_t p, input logic [VAL_W-1:0] x);
    @(negedge clk_sys);
    go = 1'h1;
    code = c;
    port = p;
    val = x;
    @(negedge clk_sys);
    go = 1'h0;
  endtask

  task push(input logic [CODE_W-1:0] c, input logic [TEXT_W-1:0] t);
    @(negedge clk_sys);
    err_push = 1'h1;
    err_code = c;
    err_text = t;
    @(negedge clk_sys);
    err_push = 1'h0;
  endtask

  task end_sim;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog cuts a hung run short
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_sim;
  end

  initial begin
    rst_n = 1'h0;
    go = 1'h0;
    code = CMD_NONE;
    port = PORT_GPIB;
    val = 16'h0000;
    local_key = 1'h0;
    err_push = 1'h0;
    err_code = 16'h0000;
    err_text = 8'h00;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'h1;
    chk(oper_en, ENABLE_RESET);
    chk_flag(remote, 1'h0);
    // Enable set and readback, first at the top of the range
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? ENABLE_MAX : 16'($random(seed));
      cmd(CMD_OPER_ENABLE_SET, PORT_GPIB, v);
      chk(oper_en, exp_enable(v));
      cmd(CMD_QUES_ENABLE_SET, PORT_GPIB, ~v);
      chk(ques_en, exp_enable(~v));
      cmd(CMD_OPER_ENABLE_Q, PORT_GPIB, 16'h0000);
      chk(rval, exp_enable(v));
      cmd(CMD_QUES_ENABLE_Q, PORT_GPIB, 16'h0000);
      chk(rval, exp_enable(~v));
      chk(oper_en, exp_enable(v));
    end
    // Condition queries with nonzero enables held; a leaked enable would show here
    for (int i = 1; i <= 2; i++) begin
      cmd(cmd_t'(i), PORT_GPIB, 16'h0000);
      chk_flag(rv, 1'h1);
      chk(rval, ZERO_VALUE);
    end
    // Event queries likewise
    for (int i = 3; i <= 4; i++) begin
      cmd(cmd_t'(i), PORT_GPIB, 16'h0000);
      chk_flag(rv, 1'h1);
      chk(rval, ZERO_VALUE);
    end
    cmd(CMD_STATUS_PRESET, PORT_SERIAL, 16'h0000);
    chk_flag(rej, 1'h1);
    chk(oper_en, exp_enable(v));
    cmd(CMD_STATUS_PRESET, PORT_GPIB, 16'h0000);
    chk(oper_en, ZERO_VALUE);
    chk(ques_en, ZERO_VALUE);
    // Session commands belong to the serial port only
    cmd(CMD_SERIAL_OPEN, PORT_GPIB, 16'h0000);
    chk_flag(rej, 1'h1);
    chk_flag(remote, 1'h0);
    // Serial session: refused before open, then open, close and local key
    cmd(CMD_ERROR_Q, PORT_SERIAL, 16'h0000);
    chk_flag(rej, 1'h1);
    cmd(CMD_SERIAL_OPEN, PORT_SERIAL, 16'h0000);
    chk_flag(remote, 1'h1);
    chk_flag(lock, 1'h1);
    cmd(CMD_ERROR_Q, PORT_SERIAL, 16'h0000);
    chk_flag(rv, 1'h1);
    cmd(CMD_SERIAL_CLOSE, PORT_SERIAL, 16'h0000);
    chk_flag(remote, 1'h0);
    chk_flag(lock, 1'h0);
    cmd(CMD_SERIAL_OPEN, PORT_SERIAL, 16'h0000);
    chk_flag(lock, 1'h1);
    @(negedge clk_sys);
    local_key = 1'h1;
    @(negedge clk_sys);
    local_key = 1'h0;
    chk_flag(lock, 1'h0);
    cmd(CMD_ERROR_Q, PORT_SERIAL, 16'h0000);
    chk_flag(rej, 1'h1);
    // Fill the queue past its depth; the extra error must be dropped
    for (int i = 0; i <= QDEPTH; i++) begin
      e = 24'($random(seed));
      push(e[23:8], e[7:0]);
      chk_flag(drop, 1'(i == QDEPTH));
      if (i < QDEPTH) q.push_back(e);
    end
    for (int i = 0; i < QDEPTH; i++) begin
      e = q.pop_front();
      cmd(CMD_ERROR_Q, PORT_GPIB, 16'h0000);
      chk(rval, e[23:8]);
      chk_text(rtext, e[7:0]);
    end
    repeat (2) begin
      cmd(CMD_ERROR_Q, PORT_GPIB, 16'h0000);
      chk_flag(rv, 1'h1);
      chk(rval, NO_ERROR_CODE);
      chk_text(rtext, NO_ERROR_TEXT);
    end
    end_sim;
  end
endmodule
`default_nettype wire
